/* File: core/mfb_fault_signal.v */
// diagnostic interrupt pulse and beep code generator
`timescale 1ns/1ps
`include "mfb_defs.vh"

module mfb_fault_signal #(
  parameter NMI_CYC   = `MFB_NMI_CYC,
  parameter MS_CYC    = `MFB_MS_CYC,
  parameter BEEP_ON   = `MFB_BEEP_ON_MS,
  parameter BEEP_GAP  = `MFB_BEEP_GAP_MS,
  parameter DIGIT_GAP = `MFB_DIGIT_GAP_MS
) (
  input  wire ref_clk,
  input  wire resetn,
  // system state and interrupt requests
  input  wire sys_reset_or_pwrdn,
  input  wire chassis_nmi_req,
  input  wire fp_nmi_button,
  input  wire wdt_pretimeout,
  input  wire wdt_action_nmi,

  // fault detections, each taken on its rising edge
  input  wire cpu_missing,
  input  wire processor_ident_match_code,
  input  wire pg_dropout,
  input  wire pwr_ctl_fault,
  input  wire voltage_regulator_watchdog,
  input  wire psu_incompat_fail,

  // toward the host
  output reg  nmi_out,
  output reg  sel_log_req,
  output reg  nmi_locked,

  // toward the beeper
  output reg  beep_out,
  output reg  beep_busy
);

  // beep sequencer states
  localparam ST_IDLE = 2'd0;
  localparam ST_ON   = 2'd1;
  localparam ST_GAP  = 2'd2;
  localparam ST_DGAP = 2'd3;

  // nmi side
  reg [31:0] nmi_cnt_r;
  reg        btn_d_r;
  reg        pto_d_r;
  reg        chs_d_r;
  wire       btn_ev = fp_nmi_button & ~btn_d_r;
  wire       pto_ev = wdt_pretimeout & wdt_action_nmi & ~pto_d_r;
  wire       chs_ev = chassis_nmi_req & ~chs_d_r;
  wire       nmi_trig = (btn_ev | pto_ev | chs_ev) & ~nmi_locked;

  // detectors reset low, so an input already high at release is an edge
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      btn_d_r <= 1'b0;
      pto_d_r <= 1'b0;
      chs_d_r <= 1'b0;
    end
    else
    begin
      btn_d_r <= fp_nmi_button;
      pto_d_r <= wdt_pretimeout & wdt_action_nmi;
      chs_d_r <= chassis_nmi_req;
    end
  end

  // logging is wanted even when the pulse is locked out
  always @(posedge ref_clk)
  begin
    if (!resetn)
      sel_log_req <= 1'b0;
    else
      sel_log_req <= btn_ev | pto_ev;
  end

  // the count restarts only on a trigger, and none can come mid-pulse
  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      nmi_out   <= 1'b0;
      nmi_cnt_r <= 32'h00000000;
    end
    else if (nmi_trig)
    begin
      nmi_out   <= 1'b1;
      nmi_cnt_r <= 32'h00000000;
    end
    else if (nmi_out)
    begin
      if (nmi_cnt_r >= NMI_CYC - 1)
        nmi_out <= 1'b0;
      else
        nmi_cnt_r <= nmi_cnt_r + 32'h00000001;
    end
  end

  // a clear seen while the pulse runs is ignored: the pulse is never cut
  always @(posedge ref_clk)
  begin
    if (!resetn)
      nmi_locked <= 1'b0;
    else if (nmi_trig)
      nmi_locked <= 1'b1;
    else if (!nmi_out && sys_reset_or_pwrdn)
      nmi_locked <= 1'b0;
  end

  // beep side: rising edge of each fault detection latches a pending bit
  wire [`MFB_NSRC-1:0] src = {psu_incompat_fail, voltage_regulator_watchdog,
                              pwr_ctl_fault, pg_dropout,
                              processor_ident_match_code, cpu_missing};
  // one pending bit per source, set by the per-source loop below
  wire [`MFB_NSRC-1:0] pend;
  reg  [`MFB_CODE_W-1:0] code_r;
  reg  [1:0]  st_r;
  reg  [1:0]  dig_idx_r;
  reg  [3:0]  beep_left_r;
  reg  [31:0] ms_cnt_r;
  reg  [15:0] ms_left_r;
  wire        ms_tick = (ms_cnt_r == MS_CYC - 1);
  wire        tmr_done = ms_tick & (ms_left_r == 16'h0000);

  // pick the lowest pending source; cpu_missing has the highest priority
  reg [`MFB_CODE_W-1:0] sel_code;
  reg [`MFB_NSRC-1:0]   sel_bit;
  reg [2:0]             sel_idx;
  integer i;
  always @*
  begin
    sel_bit = {`MFB_NSRC{1'b0}};
    sel_idx = 3'd0;
    for (i = `MFB_NSRC - 1; i >= 0; i = i - 1)
      if (pend[i])
      begin
        sel_bit    = {`MFB_NSRC{1'b0}};
        sel_bit[i] = 1'b1;
        sel_idx    = i[2:0];
      end
  end

  // code table; digits play from the top nibble down
  always @*
  begin
    case (sel_idx)
      3'd0:    sel_code = `MFB_CODE_CPU_MISS;
      3'd1:    sel_code = `MFB_CODE_IDENT;
      3'd2:    sel_code = `MFB_CODE_PG_DROP;
      3'd3:    sel_code = `MFB_CODE_PWR_CTL;
      3'd4:    sel_code = `MFB_CODE_VR_WDT;
      default: sel_code = `MFB_CODE_PSU_MIX;
    endcase
  end

  // one play per detected edge; a level never repeats it
  genvar g;
  generate
    for (g = 0; g < `MFB_NSRC; g = g + 1)
    begin : g_src
      reg edge_d_r;
      reg pend_bit_r;
      assign pend[g] = pend_bit_r;

      always @(posedge ref_clk)
      begin
        if (!resetn)
        begin
          edge_d_r   <= 1'b0;
          pend_bit_r <= 1'b0;
        end
        else
        begin
          edge_d_r <= src[g];
          // set wins over the take, so an edge is never lost
          if (src[g] & ~edge_d_r)
            pend_bit_r <= 1'b1;
          else if (st_r == ST_IDLE && sel_bit[g])
            pend_bit_r <= 1'b0;
        end
      end
    end
  endgenerate

  // the prescaler restarts with every code, so each beep is whole
  always @(posedge ref_clk)
  begin
    if (!resetn)
      ms_cnt_r <= 32'h00000000;
    else if (ms_tick || st_r == ST_IDLE)
      ms_cnt_r <= 32'h00000000;
    else
      ms_cnt_r <= ms_cnt_r + 32'h00000001;
  end

  // busy bridges the idle cycle between two queued codes
  always @(posedge ref_clk)
  begin
    if (!resetn)
      beep_busy <= 1'b0;
    else if (st_r == ST_IDLE)
      beep_busy <= |pend;
  end

  always @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      code_r      <= 16'h0000;
      st_r        <= ST_IDLE;
      dig_idx_r   <= 2'd0;
      beep_left_r <= 4'h0;
      ms_left_r   <= 16'h0000;
      beep_out    <= 1'b0;
    end
    else
    begin
      // whole milliseconds left in the current beep or pause
      if (ms_tick && ms_left_r != 16'h0000)
        ms_left_r <= ms_left_r - 16'h0001;
      case (st_r)
        ST_IDLE:
        begin
          beep_out <= 1'b0;
          if (|pend)
          begin
            // the first digit comes straight from the picker
            code_r      <= sel_code;
            dig_idx_r   <= 2'd0;
            beep_left_r <= sel_code[`MFB_CODE_W-1 -: 4];
            beep_out    <= 1'b1;
            ms_left_r   <= BEEP_ON[15:0] - 16'h0001;
            st_r        <= ST_ON;
          end
        end
        ST_ON:
          if (tmr_done)
          begin
            beep_out    <= 1'b0;
            beep_left_r <= beep_left_r - 4'h1;
            if (beep_left_r == 4'h1)
            begin
              ms_left_r <= DIGIT_GAP[15:0] - 16'h0001;
              st_r      <= ST_DGAP;
            end
            else
            begin
              ms_left_r <= BEEP_GAP[15:0] - 16'h0001;
              st_r      <= ST_GAP;
            end
          end
        ST_GAP:
          if (tmr_done)
          begin
            beep_out  <= 1'b1;
            ms_left_r <= BEEP_ON[15:0] - 16'h0001;
            st_r      <= ST_ON;
          end
        ST_DGAP:
          if (tmr_done)
          begin
            if (dig_idx_r == 2'd3)
              st_r <= ST_IDLE;
            else
            begin
              // shift the next digit up; digits play in order
              code_r      <= {code_r[`MFB_CODE_W-5:0], 4'h0};
              beep_left_r <= code_r[`MFB_CODE_W-5 -: 4];
              dig_idx_r   <= dig_idx_r + 2'd1;
              beep_out    <= 1'b1;
              ms_left_r   <= BEEP_ON[15:0] - 16'h0001;
              st_r        <= ST_ON;
            end
          end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

endmodule // mfb_fault_signal

/* File: core/mfb_defs.vh */
// constants for the fault interrupt and beep code block
`ifndef MFB_DEFS_VH
`define MFB_DEFS_VH
`define MFB_CLK_HZ        200000000
`define MFB_NMI_MIN_MS    30
`define MFB_NMI_CYC       (((`MFB_CLK_HZ / 1000) * `MFB_NMI_MIN_MS))
`define MFB_BEEP_ON_MS    100
`define MFB_BEEP_GAP_MS   100
`define MFB_DIGIT_GAP_MS  600
`define MFB_MS_CYC        (`MFB_CLK_HZ / 1000)
`define MFB_CODE_W        16
// codes as four hex digits, played from the top nibble down
`define MFB_CODE_CPU_MISS 16'h1521
`define MFB_CODE_IDENT    16'h1524
`define MFB_CODE_PG_DROP  16'h1542
`define MFB_CODE_PWR_CTL  16'h1544
`define MFB_CODE_VR_WDT   16'h1512
`define MFB_CODE_PSU_MIX  16'h1514
`define MFB_NSRC          6
`endif

/* File: bench/mfb_host_model.sv */
// host side model: counts interrupt pulses and decodes beep digits
`timescale 1ns/1ps
module mfb_host_model (
  input  wire logic        ref_clk,
  input  wire logic        nmi_out,
  input  wire logic        beep_out,
  output logic      [31:0] code,
  output int               nmi_n,
  output int               nmi_hi
);
  logic nmi_r = 1'b0;
  logic beep_r = 1'b0;
  int   run = 0;
  int   grp = 0;
  initial
  begin
    code = '0;
    nmi_n = 0;
    nmi_hi = 0;
  end
  always @(posedge ref_clk)
  begin
    nmi_r <= nmi_out;
    beep_r <= beep_out;
    nmi_hi <= nmi_hi + nmi_out;
    if (nmi_out && !nmi_r)
      nmi_n <= nmi_n + 1;
    if (beep_out && !beep_r)
      grp <= grp + 1;
    run <= beep_out ? 0 : run + 1;
    // a low run longer than a beep gap closes a digit
    if (run == 12 && grp != 0)
    begin
      code <= {code[27:0], grp[3:0]};
      grp <= 0;
    end
  end
endmodule // mfb_host_model

/* File: bench/mfb_fault_chk.sv */
// port assertions for the fault interrupt and beep block
`timescale 1ns/1ps
module mfb_fault_chk #(
  parameter NMI_CYC = 20,
  parameter MS_CYC  = 4,
  parameter BEEP_ON = 2
) (
  input wire ref_clk,
  input wire resetn,
  input wire sys_reset_or_pwrdn,
  input wire chassis_nmi_req,
  input wire fp_nmi_button,
  input wire wdt_pretimeout,
  input wire wdt_action_nmi,
  input wire nmi_out,
  input wire sel_log_req,
  input wire nmi_locked,
  input wire beep_out,
  input wire beep_busy
);
  int   nc_r = 0;
  int   bc_r = 0;
  logic fp_r = 1'b0;
  logic wd_r = 1'b0;
  logic cause_r = 1'b0;
  always @(posedge ref_clk)
  begin
    nc_r <= (resetn && nmi_out) ? nc_r + 1 : 0;
    bc_r <= (resetn && beep_out) ? bc_r + 1 : 0;
    fp_r <= resetn && fp_nmi_button;
    wd_r <= resetn && wdt_pretimeout && wdt_action_nmi;
    cause_r <= resetn && ((fp_nmi_button && !fp_r)
      || (wdt_pretimeout && wdt_action_nmi && !wd_r));
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_NMI_LEN: assert property ($fell(nmi_out) |-> nc_r == NMI_CYC)
    else $error("nmi pulse length wrong");
  AST_LOCK_HOLD: assert property (nmi_locked && !sys_reset_or_pwrdn
    |=> nmi_locked) else $error("lockout dropped");
  AST_NO_RETRIG: assert property ($rose(nmi_out) |-> !$past(nmi_locked))
    else $error("pulse while locked");
  AST_NMI_GO: assert property (
    ($rose(fp_nmi_button) || $rose(chassis_nmi_req)
    || ($rose(wdt_pretimeout) && wdt_action_nmi)) && !nmi_locked
    |=> nmi_out && nmi_locked) else $error("no pulse");
  AST_LOG_ONLY: assert property (sel_log_req |-> cause_r)
    else $error("stray log request");
  AST_LOG_MADE: assert property (cause_r |-> sel_log_req)
    else $error("missing log request");
  AST_BEEP_BUSY: assert property (beep_out |-> beep_busy)
    else $error("beep while idle");
  AST_BEEP_LEN: assert property ($fell(beep_out) |->
    bc_r == BEEP_ON * MS_CYC) else $error("beep length wrong");
  AST_BEEP_GAP: assert property ($fell(beep_out) |-> !beep_out [*8])
    else $error("beep gap short");
  cover property ($rose(nmi_out));
  cover property (sel_log_req && nmi_locked);
  cover property ($fell(beep_busy));
endmodule // mfb_fault_chk
bind mfb_fault_signal mfb_fault_chk #(.NMI_CYC(NMI_CYC), .MS_CYC(MS_CYC),
  .BEEP_ON(BEEP_ON)) chk_u (.ref_clk, .resetn, .sys_reset_or_pwrdn,
  .chassis_nmi_req, .fp_nmi_button, .wdt_pretimeout, .wdt_action_nmi,
  .nmi_out, .sel_log_req, .nmi_locked, .beep_out, .beep_busy);

/* File: bench/test_mfb_fault_signal.sv */
// self-checking bench for the fault interrupt and beep block
`timescale 1ns/1ps
module test_mfb_fault_signal;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic srp = 1'b0;
  logic chas = 1'b0;
  logic fp = 1'b0;
  logic wdt = 1'b0;
  logic act = 1'b0;
  logic [5:0] flt = 6'h00;
  wire  nmi, log_req, locked, beep, busy;
  wire  [31:0] code;
  int   nmi_n, nmi_hi;
  int   logs = 0;
  int   n_errors = 0;
  int   compares = 0;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) logs <= logs + log_req;
  mfb_fault_signal #(.NMI_CYC(20), .MS_CYC(4), .BEEP_ON(2), .BEEP_GAP(2),
    .DIGIT_GAP(5)) dut_u (.ref_clk(ref_clk), .resetn(resetn),
    .sys_reset_or_pwrdn(srp), .chassis_nmi_req(chas), .fp_nmi_button(fp),
    .wdt_pretimeout(wdt), .wdt_action_nmi(act), .cpu_missing(flt[0]),
    .processor_ident_match_code(flt[1]), .pg_dropout(flt[2]),
    .pwr_ctl_fault(flt[3]), .voltage_regulator_watchdog(flt[4]),
    .psu_incompat_fail(flt[5]), .nmi_out(nmi), .sel_log_req(log_req),
    .nmi_locked(locked), .beep_out(beep), .beep_busy(busy));
  mfb_host_model host_u (.ref_clk(ref_clk), .nmi_out(nmi), .beep_out(beep),
    .code(code), .nmi_n(nmi_n), .nmi_hi(nmi_hi));
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wait_idle;
    for (int k = 0; k < 3000 && busy !== 1'b0; k++)
      wt(1);
  endtask
  task automatic t_nmi;
    chas = 1'b1;
    wt(2);
    check(locked, 1);
    wt(30);
    check(nmi_hi, 20);
    check(logs, 0);
    fp = 1'b1;
    wt(40);
    check(nmi_n, 1);
    check(logs, 1);
    srp = 1'b1;
    wt(2);
    srp = 1'b0;
    fp = 1'b0;
    check(locked, 0);
    wt(2);
    fp = 1'b1;
    wt(30);
    check(nmi_n, 2);
    srp = 1'b1;
    wt(2);
    srp = 1'b0;
    wdt = 1'b1;
    wt(30);
    check(nmi_n, 2);
    wdt = 1'b0;
    act = 1'b1;
    wt(2);
    wdt = 1'b1;
    wt(30);
    check(nmi_n, 3);
    check(logs, 3);
    $display("nmi test done");
  endtask
  task automatic t_beep;
    logic [15:0] exp [6];
    exp = '{16'h1521, 16'h1524, 16'h1542, 16'h1544, 16'h1512, 16'h1514};
    for (int i = 0; i < 6; i++)
    begin
      flt[i] = 1'b1;
      wt(3);
      wait_idle();
      check(code[15:0], exp[i]);
    end
    wt(400);
    check(busy, 0);
    flt = 6'h00;
    wt(2);
    flt[2] = 1'b1;
    wt(20);
    flt[0] = 1'b1;
    wait_idle();
    wt(3);
    wait_idle();
    check(code, 32'h15421521);
    $display("beep test done");
  endtask
  task automatic end_sim;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_errors++;
    end_sim();
  end
  initial
  begin
    wt(16);
    resetn = 1'b1;
    t_nmi();
    t_beep();
    end_sim();
  end
endmodule // test_mfb_fault_signal
